// >>> hdl/tbw_timebase_watchdog.sv
// timebase counter, subclock interval counter and watchdog behind an axi4-lite slave
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module tbw_timebase_watchdog
    import tbw_pkg::*;
(
    // clock, reset, freeze
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // subclock pin
    input wire logic subclk_pin,
    // register bus
    input wire tbw_axi_req_type axi_req,
    output tbw_axi_rsp_type axi_rsp,
    // interrupts and cpu reset
    output logic tb_irq,
    output logic sub_irq,
    output logic cpu_reset_req,
    // counter values for other functions
    output logic [17:0] tb_count,
    output logic [14:0] sub_count
);

    tbw_state_type s_ff;
    tbw_state_type nxt_s;

    logic tb_tick;
    logic tb_evt;
    logic wd_tb_evt;
    logic sub_tick;
    logic sub_evt;
    logic wd_sub_evt;
    logic wd_tick;
    logic wr_fire;
    logic [2:0] wr_reg;
    logic wr_tb;
    logic wr_sub;
    logic wr_wd;
    logic wd_kick;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;

    // true when the increment carries into bit k
    function automatic logic carry_at(input logic [17:0] cnt, input logic [4:0] k);
        logic [17:0] mask;
        mask = (18'h1 << k) - 18'h1;
        return &(cnt | ~mask);
    endfunction

    // byte address to register selector
    function automatic logic [2:0] reg_sel(input logic [11:0] addr);
        logic [11:0] a;
        a = {addr[11:2], 2'b00};
        case (a)
            TBW_ADDR_TB_CTRL: reg_sel = TBW_REG_TB_CTRL;
            TBW_ADDR_SUB_CTRL: reg_sel = TBW_REG_SUB_CTRL;
            TBW_ADDR_WD_CTRL: reg_sel = TBW_REG_WD_CTRL;
            TBW_ADDR_TB_CNT: reg_sel = TBW_REG_TB_CNT;
            TBW_ADDR_SUB_CNT: reg_sel = TBW_REG_SUB_CNT;
            default: reg_sel = TBW_REG_NONE;
        endcase
    endfunction

    // interval taps
    function automatic logic [4:0] tb_tap(input logic [1:0] sel);
        case (sel)
            2'h0: tb_tap = TBW_TB_TAP0;
            2'h1: tb_tap = TBW_TB_TAP1;
            2'h2: tb_tap = TBW_TB_TAP2;
            default: tb_tap = TBW_TB_TAP3;
        endcase
    endfunction

    // subclock watchdog taps
    function automatic logic [4:0] wds_sub(input logic [1:0] sel);
        case (sel)
            2'h0: wds_sub = TBW_WDS_TAP0;
            2'h1: wds_sub = TBW_WDS_TAP1;
            2'h2: wds_sub = TBW_WDS_TAP2;
            default: wds_sub = TBW_WDS_TAP3;
        endcase
    endfunction

    // true in the later half of a tick period, at most half the steps left
    function automatic logic late_half(input logic [17:0] cnt, input logic [4:0] k);
        return cnt[k - 5'h1];
    endfunction

    function automatic logic [31:0] read_word(input tbw_state_type st, input logic [2:0] sel);
        logic [31:0] d;
        d = 32'h0;
        case (sel)
            TBW_REG_TB_CTRL: begin
                d[TBW_F_SEL +: 2] = st.tb_sel;
                d[TBW_F_IE] = st.tb_ie;
                d[TBW_F_OF] = st.tb_of;
            end
            TBW_REG_SUB_CTRL: begin
                d[TBW_F_SEL +: 3] = st.sub_sel;
                d[TBW_F_IE] = st.sub_ie;
                d[TBW_F_OF] = st.sub_of;
                d[TBW_F_WDSRC] = st.wd_src;
            end
            TBW_REG_WD_CTRL: begin
                d[TBW_F_SEL +: 2] = st.wd_sel;
                d[TBW_F_WDON] = (st.wd_state == TBW_WD_ON);
                d[TBW_F_WDCNT +: 2] = st.wd_cnt;
            end
            TBW_REG_TB_CNT: d[TBW_TB_W-1:0] = st.tb_cnt;
            TBW_REG_SUB_CNT: d[TBW_SUB_W-1:0] = st.sub_cnt;
            default: d = 32'h0;
        endcase
        return d;
    endfunction

    // tick and carry events
    assign tb_tick = s_ff.half;
    assign tb_evt = tb_tick & carry_at(s_ff.tb_cnt, tb_tap(s_ff.tb_sel));
    assign wd_tb_evt = tb_tick & carry_at(s_ff.tb_cnt, tb_tap(s_ff.wd_sel));
    assign sub_tick = s_ff.sub_s2 & ~s_ff.sub_prev;
    assign sub_evt = sub_tick & carry_at({3'h0, s_ff.sub_cnt}, TBW_SUB_TAP_BASE + {2'h0, s_ff.sub_sel});
    assign wd_sub_evt = sub_tick & carry_at({3'h0, s_ff.sub_cnt}, wds_sub(s_ff.wd_sel));
    assign wd_tick = s_ff.wd_src ? wd_tb_evt : wd_sub_evt;

    // bus handshakes and write decode
    assign aw_hs = axi_req.awvalid & ~s_ff.aw_vld & ~s_ff.bvalid;
    assign w_hs = axi_req.wvalid & ~s_ff.w_vld & ~s_ff.bvalid;
    assign ar_hs = axi_req.arvalid & ~s_ff.rvalid;
    assign wr_fire = s_ff.aw_vld & s_ff.w_vld & ~s_ff.bvalid;
    assign wr_reg = reg_sel(s_ff.aw_addr);
    assign wr_tb = wr_fire & s_ff.w_strb[0] & (wr_reg == TBW_REG_TB_CTRL);
    assign wr_sub = wr_fire & s_ff.w_strb[0] & (wr_reg == TBW_REG_SUB_CTRL);
    assign wr_wd = wr_fire & s_ff.w_strb[0] & (wr_reg == TBW_REG_WD_CTRL);
    assign wd_kick = wr_wd & s_ff.w_data[TBW_F_WDKICK];

    always_comb begin
        nxt_s = s_ff;
        nxt_s.cpu_rst = 1'b0;
        // oscillation clock divided by two
        nxt_s.half = ~s_ff.half;
        if (tb_tick) begin
            nxt_s.tb_cnt = s_ff.tb_cnt + 18'h1;
        end
        if (wr_tb) begin
            nxt_s.tb_sel = s_ff.w_data[TBW_F_SEL +: 2];
            nxt_s.tb_ie = s_ff.w_data[TBW_F_IE];
            if (s_ff.w_data[TBW_F_CLR]) begin
                nxt_s.tb_cnt = 18'h0;
            end
            if (!s_ff.w_data[TBW_F_OF]) begin
                nxt_s.tb_of = 1'b0;
            end
        end
        if (tb_evt) begin
            nxt_s.tb_of = 1'b1;
        end
        // subclock pin synchroniser and counter
        nxt_s.sub_s1 = subclk_pin;
        nxt_s.sub_s2 = s_ff.sub_s1;
        nxt_s.sub_prev = s_ff.sub_s2;
        if (sub_tick) begin
            nxt_s.sub_cnt = s_ff.sub_cnt + 15'h1;
        end
        if (wr_sub) begin
            nxt_s.sub_sel = s_ff.w_data[TBW_F_SEL +: 3];
            nxt_s.sub_ie = s_ff.w_data[TBW_F_IE];
            nxt_s.wd_src = s_ff.w_data[TBW_F_WDSRC];
            if (s_ff.w_data[TBW_F_CLR]) begin
                nxt_s.sub_cnt = 15'h0;
            end
            if (!s_ff.w_data[TBW_F_OF]) begin
                nxt_s.sub_of = 1'b0;
            end
        end
        if (sub_evt) begin
            nxt_s.sub_of = 1'b1;
        end
        // watchdog
        if (wr_wd) begin
            nxt_s.wd_sel = s_ff.w_data[TBW_F_SEL +: 2];
        end
        case (s_ff.wd_state)
            TBW_WD_OFF: begin
                if (wd_kick) begin
                    nxt_s.wd_state = TBW_WD_ON;
                end
            end
            TBW_WD_ON: begin
                if (!wd_kick && wd_tick) begin
                    if (s_ff.wd_skip) begin
                        nxt_s.wd_skip = 1'b0;
                    end else if (s_ff.wd_cnt == TBW_WD_LAST) begin
                        nxt_s.cpu_rst = 1'b1;
                        nxt_s.wd_cnt = 2'h0;
                    end else begin
                        nxt_s.wd_cnt = s_ff.wd_cnt + 2'h1;
                    end
                end
            end
            default: nxt_s.wd_state = TBW_WD_OFF;
        endcase
        // clear late in a tick period waits one extra tick, centring expiry on the interval
        if (wd_kick) begin
            nxt_s.wd_cnt = 2'h0;
            nxt_s.wd_skip = s_ff.wd_src ?
                late_half(nxt_s.tb_cnt, tb_tap(s_ff.w_data[TBW_F_SEL +: 2])) :
                late_half({3'h0, nxt_s.sub_cnt}, wds_sub(s_ff.w_data[TBW_F_SEL +: 2]));
        end
        // write channel
        if (aw_hs) begin
            nxt_s.aw_vld = 1'b1;
            nxt_s.aw_addr = axi_req.awaddr;
        end
        if (w_hs) begin
            nxt_s.w_vld = 1'b1;
            nxt_s.w_data = axi_req.wdata;
            nxt_s.w_strb = axi_req.wstrb;
        end
        if (wr_fire) begin
            nxt_s.aw_vld = 1'b0;
            nxt_s.w_vld = 1'b0;
            nxt_s.bvalid = 1'b1;
            nxt_s.bresp = (wr_reg == TBW_REG_NONE) ? TBW_RESP_SLVERR : TBW_RESP_OKAY;
        end
        if (s_ff.bvalid && axi_req.bready) begin
            nxt_s.bvalid = 1'b0;
        end
        // read channel
        if (ar_hs) begin
            nxt_s.rvalid = 1'b1;
            nxt_s.rdata = read_word(s_ff, reg_sel(axi_req.araddr));
            nxt_s.rresp = (reg_sel(axi_req.araddr) == TBW_REG_NONE) ?
                TBW_RESP_SLVERR : TBW_RESP_OKAY;
        end
        if (s_ff.rvalid && axi_req.rready) begin
            nxt_s.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_ff <= TBW_STATE_RST;
        end else if (ce) begin
            s_ff <= nxt_s;
        end
    end

    // outputs
    always_comb begin
        axi_rsp.awready = ~s_ff.aw_vld & ~s_ff.bvalid;
        axi_rsp.wready = ~s_ff.w_vld & ~s_ff.bvalid;
        axi_rsp.bvalid = s_ff.bvalid;
        axi_rsp.bresp = s_ff.bresp;
        axi_rsp.arready = ~s_ff.rvalid;
        axi_rsp.rvalid = s_ff.rvalid;
        axi_rsp.rdata = s_ff.rdata;
        axi_rsp.rresp = s_ff.rresp;
    end

    assign tb_irq = s_ff.tb_of & s_ff.tb_ie;
    assign sub_irq = s_ff.sub_of & s_ff.sub_ie;
    assign cpu_reset_req = s_ff.cpu_rst;
    assign tb_count = s_ff.tb_cnt;
    assign sub_count = s_ff.sub_cnt;

    // checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_wd_last_tick;
        ce && s_ff.wd_state == TBW_WD_ON && s_ff.wd_cnt == TBW_WD_LAST && wd_tick && !wd_kick;
    endsequence

    sequence s_kick;
        ce && wd_kick;
    endsequence

    property p_tb_count;
        ce && tb_tick && !wr_tb |=> tb_count == $past(tb_count) + 18'h1;
    endproperty
    a_tb_count: assert property (p_tb_count) else $error("time-base count missed");

    property p_tb_half;
        ce && !wr_tb ##1 ce && !wr_tb |=> tb_count == $past(tb_count, 2) + 18'h1;
    endproperty
    a_tb_half: assert property (p_tb_half) else $error("time-base rate wrong");

    property p_tb_flag;
        ce && tb_evt |=> s_ff.tb_of;
    endproperty
    a_tb_flag: assert property (p_tb_flag) else $error("time-base flag not set");

    property p_tb_irq;
        ce && !wr_tb |=> tb_irq == $past(tb_irq || (tb_evt && s_ff.tb_ie));
    endproperty
    a_tb_irq: assert property (p_tb_irq) else $error("time-base irq wrong");

    property p_sub_count;
        ce && sub_tick && !wr_sub |=> sub_count == $past(sub_count) + 15'h1;
    endproperty
    a_sub_count: assert property (p_sub_count) else $error("subclock count missed");

    property p_sub_flag;
        ce && sub_evt && !s_ff.sub_of |=> s_ff.sub_of && (sub_irq == s_ff.sub_ie);
    endproperty
    a_sub_flag: assert property (p_sub_flag) else $error("subclock flag or irq wrong");

    property p_wd_expire;
        s_wd_last_tick |=> cpu_reset_req ##1 (!cpu_reset_req || !$past(ce));
    endproperty
    a_wd_expire: assert property (p_wd_expire) else $error("watchdog reset wrong");

    property p_wd_quiet;
        s_kick |=> s_ff.wd_cnt == 2'h0 && !cpu_reset_req;
    endproperty
    a_wd_quiet: assert property (p_wd_quiet) else $error("watchdog clear failed");

    property p_flag_clear;
        ce && wr_tb && !s_ff.w_data[TBW_F_OF] && !tb_evt |=> !s_ff.tb_of && !tb_irq;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag clear failed");

    property p_wd_src;
        ce && s_ff.wd_state == TBW_WD_ON && !wd_kick && !wd_tb_evt && !wd_sub_evt
            |=> s_ff.wd_cnt == $past(s_ff.wd_cnt);
    endproperty
    a_wd_src: assert property (p_wd_src) else $error("watchdog ticked without source");

endmodule

// >>> hdl/tbw_pkg.sv
// package: register map, field layout, taps and state carrier of the timebase watchdog
package tbw_pkg;

    // register byte offsets
    localparam logic [11:0] TBW_ADDR_TB_CTRL = 12'h000;
    localparam logic [11:0] TBW_ADDR_SUB_CTRL = 12'h004;
    localparam logic [11:0] TBW_ADDR_WD_CTRL = 12'h008;
    localparam logic [11:0] TBW_ADDR_TB_CNT = 12'h00c;
    localparam logic [11:0] TBW_ADDR_SUB_CNT = 12'h010;

    // decoded register selector
    localparam logic [2:0] TBW_REG_TB_CTRL = 3'h0;
    localparam logic [2:0] TBW_REG_SUB_CTRL = 3'h1;
    localparam logic [2:0] TBW_REG_WD_CTRL = 3'h2;
    localparam logic [2:0] TBW_REG_TB_CNT = 3'h3;
    localparam logic [2:0] TBW_REG_SUB_CNT = 3'h4;
    localparam logic [2:0] TBW_REG_NONE = 3'h7;

    // field positions
    localparam int TBW_F_SEL = 0;
    localparam int TBW_F_CLR = 3;
    localparam int TBW_F_IE = 4;
    localparam int TBW_F_OF = 5;
    localparam int TBW_F_WDSRC = 6;
    localparam int TBW_F_WDKICK = 2;
    localparam int TBW_F_WDON = 3;
    localparam int TBW_F_WDCNT = 4;

    // counter widths
    localparam int TBW_TB_W = 18;
    localparam int TBW_SUB_W = 15;

    // carry tap bit per selection (timebase counter advances every two oscillation periods, subclock counter once per subclock rising edge)
    localparam logic [4:0] TBW_TB_TAP0 = 5'h0b;
    localparam logic [4:0] TBW_TB_TAP1 = 5'h0d;
    localparam logic [4:0] TBW_TB_TAP2 = 5'h0f;
    localparam logic [4:0] TBW_TB_TAP3 = 5'h12;
    localparam logic [4:0] TBW_WDS_TAP0 = 5'h0a;
    localparam logic [4:0] TBW_WDS_TAP1 = 5'h0d;
    localparam logic [4:0] TBW_WDS_TAP2 = 5'h0e;
    localparam logic [4:0] TBW_WDS_TAP3 = 5'h0f;
    localparam logic [4:0] TBW_SUB_TAP_BASE = 5'h08;

    // watchdog expiry count and interrupt request numbers
    localparam logic [1:0] TBW_WD_LAST = 2'h3;
    localparam logic [5:0] TBW_TB_IRQ_NUM = 6'h10;
    localparam logic [5:0] TBW_SUB_IRQ_NUM = 6'h1c;

    // axi responses
    localparam logic [1:0] TBW_RESP_OKAY = 2'h0;
    localparam logic [1:0] TBW_RESP_SLVERR = 2'h2;

    typedef enum logic [0:0] {
        TBW_WD_OFF = 1'b0,
        TBW_WD_ON = 1'b1
    } tbw_wd_state_type;

    typedef struct packed {
        logic awvalid;
        logic [11:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [11:0] araddr;
        logic rready;
    } tbw_axi_req_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tbw_axi_rsp_type;

    typedef struct packed {
        logic half;
        logic [17:0] tb_cnt;
        logic [1:0] tb_sel;
        logic tb_ie;
        logic tb_of;
        logic sub_s1;
        logic sub_s2;
        logic sub_prev;
        logic [14:0] sub_cnt;
        logic [2:0] sub_sel;
        logic sub_ie;
        logic sub_of;
        logic wd_src;
        tbw_wd_state_type wd_state;
        logic [1:0] wd_sel;
        logic [1:0] wd_cnt;
        logic wd_skip;
        logic cpu_rst;
        logic aw_vld;
        logic [11:0] aw_addr;
        logic w_vld;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tbw_state_type;

    localparam tbw_state_type TBW_STATE_RST = '0;

endpackage

// >>> bench/tbw_cpu_model.sv
// partner: processor reset and interrupt intake facing the timebase watchdog
`timescale 1ns/1ps
module tbw_cpu_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // requests from the block
    input wire logic tb_irq,
    input wire logic sub_irq,
    input wire logic cpu_reset_req,
    // observed intake
    output logic [7:0] rst_seen,
    output logic [5:0] irq_num
);
    always @(posedge aclk) begin
        if (!aresetn) begin
            rst_seen <= 8'h00;
            irq_num <= 6'h00;
        end else begin
            if (cpu_reset_req) begin
                rst_seen <= rst_seen + 8'h01;
            end
            if (tb_irq) begin
                irq_num <= 6'h10;
            end else if (sub_irq) begin
                irq_num <= 6'h1c;
            end
        end
    end
endmodule

// >>> bench/tb_top.sv
// testbench: timebase, subclock timer and watchdog checked over axi4-lite
`timescale 1ns/1ps
module tb_top;
    import tbw_pkg::*;
    logic aclk;
    logic aresetn;
    logic ce;
    logic subclk_pin;
    logic [2:0] sdiv;
    tbw_axi_req_type req;
    tbw_axi_rsp_type rsp;
    logic tb_irq;
    logic sub_irq;
    logic cpu_reset_req;
    logic [17:0] tb_count;
    logic [14:0] sub_count;
    logic [7:0] rst_seen;
    logic [5:0] irq_num;
    logic [1:0] resp;
    logic [31:0] rd;
    int mismatches;
    int compares;

    tbw_timebase_watchdog dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .subclk_pin(subclk_pin), .axi_req(req), .axi_rsp(rsp), .tb_irq(tb_irq),
        .sub_irq(sub_irq), .cpu_reset_req(cpu_reset_req), .tb_count(tb_count),
        .sub_count(sub_count));
    tbw_cpu_model cpu (.aclk(aclk), .aresetn(aresetn), .tb_irq(tb_irq), .sub_irq(sub_irq),
        .cpu_reset_req(cpu_reset_req), .rst_seen(rst_seen), .irq_num(irq_num));

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // subclock pin, four cycles high and four low
    always @(posedge aclk) begin
        if (!aresetn) begin
            sdiv <= 3'h0;
            subclk_pin <= 1'b0;
        end else begin
            sdiv <= sdiv + 3'h1;
            subclk_pin <= sdiv[2];
        end
    end

    task automatic end_sim();
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_rng(input string what, input int lo, input int hi, input int got);
        compares++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    task automatic give_up(input string what);
        mismatches++;
        $display("[ERR] %s expected answer seen timeout", what);
        end_sim();
    endtask

    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_hit;
        logic w_hit;
        logic b_hit;
        int n;
        b_hit = 1'b0;
        n = 0;
        @(posedge aclk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        while (!b_hit) begin
            @(negedge aclk);
            aw_hit = req.awvalid && rsp.awready;
            w_hit = req.wvalid && rsp.wready;
            b_hit = rsp.bvalid === 1'b1;
            r = rsp.bresp;
            @(posedge aclk);
            if (aw_hit) req.awvalid <= 1'b0;
            if (w_hit) req.wvalid <= 1'b0;
            n++;
            if (n > 50) give_up("write response");
        end
        req.bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_hit;
        logic r_hit;
        int n;
        r_hit = 1'b0;
        n = 0;
        @(posedge aclk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        while (!r_hit) begin
            @(negedge aclk);
            ar_hit = req.arvalid && rsp.arready;
            r_hit = rsp.rvalid === 1'b1;
            d = rsp.rdata;
            r = rsp.rresp;
            @(posedge aclk);
            if (ar_hit) req.arvalid <= 1'b0;
            n++;
            if (n > 50) give_up("read response");
        end
        req.rready <= 1'b0;
    endtask

    task automatic wait_hi(input int which, input int lim, output int cyc);
        logic hit;
        hit = 1'b0;
        cyc = 0;
        while (!hit) begin
            @(negedge aclk);
            cyc++;
            hit = ((which == 0) ? tb_irq : (which == 1) ? sub_irq : cpu_reset_req) === 1'b1;
            if (cyc > lim) give_up("event wait");
        end
    endtask

    task automatic t_reset_vals();
        axi_rd(TBW_ADDR_TB_CTRL, rd, resp);
        chk("tb ctrl", 32'h0, rd);
        axi_rd(TBW_ADDR_SUB_CTRL, rd, resp);
        chk("sub ctrl", 32'h0, rd);
        axi_rd(TBW_ADDR_WD_CTRL, rd, resp);
        chk("wd ctrl", 32'h0, rd);
        axi_rd(12'h020, rd, resp);
        chk("unmapped rresp", 32'h2, {30'h0, resp});
        axi_wr(12'h020, 32'h1, resp);
        chk("unmapped bresp", 32'h2, {30'h0, resp});
        axi_wr(TBW_ADDR_TB_CNT, 32'h0, resp);
        chk("ro bresp", 32'h0, {30'h0, resp});
    endtask

    task automatic t_timebase();
        logic [17:0] v0;
        int cyc;
        axi_wr(TBW_ADDR_TB_CTRL, 32'h18, resp);
        wait_hi(0, 4200, cyc);
        chk_rng("tb irq delay", 4090, 4100, cyc);
        @(negedge aclk);
        chk("tb irq line", 32'h10, {26'h0, irq_num});
        v0 = tb_count;
        repeat (2) @(negedge aclk);
        chk("tb count step", {14'h0, v0 + 18'h1}, {14'h0, tb_count});
        @(posedge aclk);
        ce <= 1'b0;
        @(negedge aclk);
        v0 = tb_count;
        repeat (4) @(posedge aclk);
        ce <= 1'b1;
        @(negedge aclk);
        chk("tb count frozen", {14'h0, v0}, {14'h0, tb_count});
        axi_rd(TBW_ADDR_TB_CTRL, rd, resp);
        chk("tb flag", 32'h30, rd);
        axi_wr(TBW_ADDR_TB_CTRL, 32'h20, resp);
        chk("tb irq masked", 32'h0, {31'h0, tb_irq});
        axi_wr(TBW_ADDR_TB_CTRL, 32'h30, resp);
        chk("tb irq unmasked", 32'h1, {31'h0, tb_irq});
        axi_wr(TBW_ADDR_TB_CTRL, 32'h10, resp);
        chk("tb irq cleared", 32'h0, {31'h0, tb_irq});
        for (int s = 0; s < 4; s++) begin
            axi_wr(TBW_ADDR_TB_CTRL, s, resp);
            axi_rd(TBW_ADDR_TB_CTRL, rd, resp);
            chk("tb sel", s, rd);
        end
    endtask

    task automatic t_subclock();
        int cyc;
        axi_wr(TBW_ADDR_SUB_CTRL, 32'h18, resp);
        wait_hi(1, 2200, cyc);
        chk_rng("sub irq delay", 2030, 2065, cyc);
        chk("sub count", 32'h100, {17'h0, sub_count});
        @(negedge aclk);
        chk("sub irq line", 32'h1c, {26'h0, irq_num});
        axi_wr(TBW_ADDR_SUB_CTRL, 32'h10, resp);
        chk("sub irq cleared", 32'h0, {31'h0, sub_irq});
        for (int s = 0; s < 8; s++) begin
            axi_wr(TBW_ADDR_SUB_CTRL, s, resp);
            axi_rd(TBW_ADDR_SUB_CTRL, rd, resp);
            chk("sub sel", s, rd);
        end
    endtask

    task automatic t_wd_tb();
        logic [7:0] n0;
        int cyc;
        axi_wr(TBW_ADDR_SUB_CTRL, 32'h40, resp);
        axi_wr(TBW_ADDR_TB_CTRL, 32'h08, resp);
        axi_wr(TBW_ADDR_WD_CTRL, 32'h04, resp);
        axi_rd(TBW_ADDR_WD_CTRL, rd, resp);
        chk("wd active", 32'h08, rd);
        n0 = rst_seen;
        repeat (2) begin
            repeat (10000) @(posedge aclk);
            axi_wr(TBW_ADDR_WD_CTRL, 32'h04, resp);
        end
        chk("no early reset", {24'h0, n0}, {24'h0, rst_seen});
        wait_hi(2, 19000, cyc);
        chk_rng("wd tb reset", 14330, 18440, cyc);
        @(negedge aclk);
        chk("reset taken", {24'h0, n0 + 8'h01}, {24'h0, rst_seen});
        axi_rd(TBW_ADDR_WD_CTRL, rd, resp);
        chk("wd still on", 32'h08, rd);
    endtask

    task automatic t_wd_sub();
        int cyc;
        axi_wr(TBW_ADDR_SUB_CTRL, 32'h00, resp);
        axi_wr(TBW_ADDR_WD_CTRL, 32'h04, resp);
        wait_hi(2, 37000, cyc);
        chk_rng("wd sub reset", 28650, 36880, cyc);
    endtask

    initial begin
        mismatches = 0;
        compares = 0;
        aresetn = 1'b0;
        ce = 1'b1;
        req = '0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_vals();
        t_timebase();
        t_subclock();
        t_wd_tb();
        t_wd_sub();
        end_sim();
    end
endmodule
